// ==== logic/fpec_top.sv ====
// Flash program/erase control registers and write-protected watchdog behind an APB slave.
`timescale 1ns/1ps
`include "fpec_defines.svh"
module fpec_top
  import fpec_pkg::*;
#(
  parameter int SYS_DIV = `FPEC_SYS_DIV,
  parameter int SUB_DIV = `FPEC_SUB_DIV
) (
  // Clock and reset.
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  // Subclock tick, one cycle per subclock period, synchronous to i_clk.
  input  wire logic        i_sub_tick,
  // APB slave.
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [17:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  // Flash mode outputs.
  output logic             o_program_mode,
  output logic             o_erase_mode,
  output logic             o_program_setup,
  output logic             o_erase_verify,
  output logic             o_program_verify,
  output fpec_mode_t       o_mode,
  // Watchdog and interrupt.
  output logic             o_wd_reset,
  output logic             o_irq
);
  logic [7:0]  flash_control_1;
  logic [7:0]  watchdog_control_status;
  logic [7:0]  watchdog_counter;
  logic [7:0]  port_mode_two;
  logic [1:0]  irq_status;
  logic [1:0]  irq_mask;
  logic [12:0] prescale;
  logic [7:0]  rst_cnt;
  logic        wd_tick;
  logic        overflow;
  logic        wr_acc;
  logic        rd_acc;
  logic        addr_hit;
  logic        software_write_enable;
  logic        watchdog_on;
  logic        next_prog;
  logic        next_erase;
  fpec_mode_t  next_mode;

  // Access phase completes in one cycle since pready is registered from the setup phase.
  assign wr_acc   = i_psel & i_penable & o_pready & i_pwrite;
  assign rd_acc   = i_psel & i_penable & o_pready & ~i_pwrite;
  assign addr_hit = (i_paddr == `FPEC_OFS_FLASH_CTRL) | (i_paddr == `FPEC_OFS_WD_CTRL) |
                    (i_paddr == `FPEC_OFS_WD_COUNT) | (i_paddr == `FPEC_OFS_PORT_MODE2) |
                    (i_paddr == `FPEC_OFS_IRQ_STATUS) | (i_paddr == `FPEC_OFS_IRQ_MASK);

  assign software_write_enable = flash_control_1[`FPEC_FC_WREN];
  assign watchdog_on           = watchdog_control_status[`FPEC_WD_ON];

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
    end else begin
      o_pready  <= i_psel & ~i_penable;
      o_pslverr <= i_psel & ~i_penable & ~addr_hit;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_prdata <= 32'h0000_0000;
    end else if (i_psel & ~i_penable & ~i_pwrite) begin
      case (i_paddr)
        `FPEC_OFS_FLASH_CTRL: o_prdata <= {24'h000000, flash_control_1};
        `FPEC_OFS_WD_CTRL:    o_prdata <= {24'h000000, watchdog_control_status};
        `FPEC_OFS_WD_COUNT:   o_prdata <= {24'h000000, watchdog_counter};
        `FPEC_OFS_PORT_MODE2: o_prdata <= {24'h000000, port_mode_two};
        `FPEC_OFS_IRQ_STATUS: o_prdata <= {30'h00000000, irq_status};
        `FPEC_OFS_IRQ_MASK:   o_prdata <= {30'h00000000, irq_mask};
        default:              o_prdata <= 32'h0000_0000;
      endcase
    end
  end

  // Flash control register bits 6:0 are plain read/write and bit 7 always reads 0; mode gating happens below.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      flash_control_1 <= `FPEC_FC_RESET;
    end else if (wr_acc && i_paddr == `FPEC_OFS_FLASH_CTRL) begin
      flash_control_1 <= {1'b0, i_pwdata[6:0]};
    end
  end

  always_comb begin
    next_prog  = software_write_enable & flash_control_1[`FPEC_FC_PSETUP]
               & flash_control_1[`FPEC_FC_P];
    next_erase = software_write_enable & flash_control_1[`FPEC_FC_ESETUP]
               & flash_control_1[`FPEC_FC_E];
    if (next_prog | next_erase) begin
      next_mode = FPEC_PROG;
    end else if (flash_control_1[`FPEC_FC_PVFY] | flash_control_1[`FPEC_FC_EVFY]) begin
      next_mode = FPEC_VERIFY;
    end else if (flash_control_1[`FPEC_FC_PSETUP] | flash_control_1[`FPEC_FC_ESETUP]) begin
      next_mode = FPEC_SETUP;
    end else begin
      next_mode = FPEC_IDLE;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_program_mode   <= 1'b0;
      o_erase_mode     <= 1'b0;
      o_program_setup  <= 1'b0;
      o_erase_verify   <= 1'b0;
      o_program_verify <= 1'b0;
      o_mode           <= FPEC_IDLE;
    end else begin
      o_program_mode   <= next_prog;
      o_erase_mode     <= next_erase;
      o_program_setup  <= software_write_enable & flash_control_1[`FPEC_FC_PSETUP];
      o_erase_verify   <= flash_control_1[`FPEC_FC_EVFY];
      o_program_verify <= flash_control_1[`FPEC_FC_PVFY];
      o_mode           <= next_mode;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      port_mode_two <= `FPEC_PM2_RESET;
    end else if (wr_acc && i_paddr == `FPEC_OFS_PORT_MODE2) begin
      port_mode_two <= i_pwdata[7:0];
    end
  end

  // Prescaler: one tick per SYS_DIV system clocks or per SUB_DIV subclock ticks.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      prescale <= 13'h0000;
      wd_tick  <= 1'b0;
    end else if (!watchdog_on) begin
      prescale <= 13'h0000;
      wd_tick  <= 1'b0;
    end else if (port_mode_two[`FPEC_PM2_CKS]) begin
      wd_tick  <= i_sub_tick && (prescale >= 13'(SUB_DIV - 1));
      if (i_sub_tick) begin
        prescale <= (prescale >= 13'(SUB_DIV - 1)) ? 13'h0000 : prescale + 13'h0001;
      end
    end else begin
      // Wrap at the divider, not at the counter width, so a shortened divider still works.
      wd_tick  <= (prescale >= 13'(SYS_DIV - 1));
      prescale <= (prescale >= 13'(SYS_DIV - 1)) ? 13'h0000 : prescale + 13'h0001;
    end
  end

  assign overflow = watchdog_on & wd_tick & (watchdog_counter == 8'hff);

  // Counter writes need the counter write-enable already set to 1 by an earlier control write,
  // which itself needs its inhibit bit written 0.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      watchdog_counter <= `FPEC_WD_COUNT_RESET;
    end else if (wr_acc && i_paddr == `FPEC_OFS_WD_COUNT
                 && watchdog_control_status[`FPEC_WD_CNT_WE]) begin
      watchdog_counter <= i_pwdata[7:0];
    end else if (watchdog_on && wd_tick) begin
      watchdog_counter <= watchdog_counter + 8'h01;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      watchdog_control_status <= `FPEC_WD_CTRL_RESET;
    end else begin
      if (wr_acc && i_paddr == `FPEC_OFS_WD_CTRL) begin
        watchdog_control_status[7] <= i_pwdata[7];
        watchdog_control_status[5] <= i_pwdata[5];
        watchdog_control_status[3] <= i_pwdata[3];
        watchdog_control_status[1] <= i_pwdata[1];
        if (!i_pwdata[7]) watchdog_control_status[6] <= i_pwdata[6];
        if (!i_pwdata[5]) watchdog_control_status[4] <= i_pwdata[4];
        if (!i_pwdata[3] && watchdog_control_status[`FPEC_WD_CTL_WE]) begin
          watchdog_control_status[2] <= i_pwdata[2];
        end
        if (!i_pwdata[1] && watchdog_control_status[`FPEC_WD_CTL_WE]) begin
          watchdog_control_status[0] <= i_pwdata[0];
        end
      end
      if (overflow) watchdog_control_status[`FPEC_WD_FLAG] <= 1'b1;
    end
  end

  // Internal reset pulse of fixed length; registers are not cleared so software can see the flag.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_cnt    <= 8'h00;
      o_wd_reset <= 1'b0;
    end else begin
      if (overflow) begin
        rst_cnt <= `FPEC_RST_PULSE_CYC;
      end else if (rst_cnt != 8'h00) begin
        rst_cnt <= rst_cnt - 8'h01;
      end
      o_wd_reset <= overflow | (rst_cnt > 8'h01);
    end
  end

  // Status bit 0: watchdog overflow, bit 1: program pulse started. Set wins over clear.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_status <= 2'b00;
      irq_mask   <= 2'b00;
      o_irq      <= 1'b0;
    end else begin
      if (wr_acc && i_paddr == `FPEC_OFS_IRQ_MASK) irq_mask <= i_pwdata[1:0];
      irq_status <= (irq_status & ~((wr_acc && i_paddr == `FPEC_OFS_IRQ_STATUS) ?
                    i_pwdata[1:0] : 2'b00)) | {next_prog & ~o_program_mode, overflow};
      o_irq      <= |(irq_status & irq_mask);
    end
  end

  property p_prog_gate;
    @(posedge i_clk) disable iff (!i_rst_n)
      o_program_mode |-> $past(software_write_enable & flash_control_1[`FPEC_FC_PSETUP]);
  endproperty
  a_prog_gate: assert property (p_prog_gate) else $error("program mode without enables");

  property p_swe_block;
    @(posedge i_clk) disable iff (!i_rst_n)
      !software_write_enable |=> !o_program_mode && !o_erase_mode;
  endproperty
  a_swe_block: assert property (p_swe_block) else $error("write-enable low not blocking");

  property p_setup;
    @(posedge i_clk) disable iff (!i_rst_n)
      1'b1 |=> o_program_setup == $past(software_write_enable & flash_control_1[`FPEC_FC_PSETUP]);
  endproperty
  a_setup: assert property (p_setup) else $error("program setup mismatch");

  property p_ev;
    @(posedge i_clk) disable iff (!i_rst_n)
      $rose(flash_control_1[`FPEC_FC_EVFY]) |=> o_erase_verify;
  endproperty
  a_ev: assert property (p_ev) else $error("erase verify not entered");

  property p_pv;
    @(posedge i_clk) disable iff (!i_rst_n)
      $fell(flash_control_1[`FPEC_FC_PVFY]) |=> !o_program_verify;
  endproperty
  a_pv: assert property (p_pv) else $error("program verify not cancelled");

  property p_inhibit;
    @(posedge i_clk) disable iff (!i_rst_n)
      (wr_acc && i_paddr == `FPEC_OFS_WD_CTRL && i_pwdata[7]) |=>
        $stable(watchdog_control_status[6]);
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("inhibited bit changed");

  property p_cnt_we;
    @(posedge i_clk) disable iff (!i_rst_n)
      (wr_acc && i_paddr == `FPEC_OFS_WD_COUNT && !watchdog_control_status[6] && !wd_tick)
        |=> $stable(watchdog_counter);
  endproperty
  a_cnt_we: assert property (p_cnt_we) else $error("counter write not blocked");

  sequence s_ovf;
    overflow;
  endsequence
  property p_ovf;
    @(posedge i_clk) disable iff (!i_rst_n)
      s_ovf |=> watchdog_control_status[0] && o_wd_reset && watchdog_counter == 8'h00;
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow effects missing");

  property p_wd_off;
    @(posedge i_clk) disable iff (!i_rst_n)
      (!watchdog_on && !(wr_acc && i_paddr == `FPEC_OFS_WD_COUNT))
        |=> $stable(watchdog_counter);
  endproperty
  a_wd_off: assert property (p_wd_off) else $error("counter moved while watchdog off");

  property p_ctl_we;
    @(posedge i_clk) disable iff (!i_rst_n)
      (wr_acc && i_paddr == `FPEC_OFS_WD_CTRL && !watchdog_control_status[`FPEC_WD_CTL_WE])
        |=> $stable(watchdog_control_status[`FPEC_WD_ON]);
  endproperty
  a_ctl_we: assert property (p_ctl_we) else $error("watchdog-on changed while locked");

  property p_count;
    @(posedge i_clk) disable iff (!i_rst_n)
      (watchdog_on && wd_tick && !(wr_acc && i_paddr == `FPEC_OFS_WD_COUNT))
        |=> watchdog_counter == $past(watchdog_counter) + 8'h01;
  endproperty
  a_count: assert property (p_count) else $error("counter did not advance on tick");

  // With the subclock selected, only a subclock tick may advance the prescaler.
  property p_sub_src;
    @(posedge i_clk) disable iff (!i_rst_n)
      (watchdog_on && port_mode_two[`FPEC_PM2_CKS] && !i_sub_tick) |=> !wd_tick;
  endproperty
  a_sub_src: assert property (p_sub_src) else $error("tick without subclock");
endmodule : fpec_top

// ==== logic/fpec_defines.svh ====
// Register offsets, field positions, reset values and timing counts of the flash control block.
// Operation
// - Write-enable bit 0 blocks all program and erase; 1 permits them.
// - Program-setup bit 1 enters program setup state; 0 cancels it.
// - Program mode only while write-enable, setup and pulse all 1; pulse clear cancels.
// - Erase-verify bit 1 enters erase-verify mode; 0 cancels it.
// - Program-verify bit 1 enters program-verify mode; 0 cancels it.
// - Inhibit bits 7,5,3,1 allow a write to the bit below only when written 0.
// - Counter write-enable 1 permits counter writes; otherwise counter writes are ignored.
// - Control write-enable 1 permits writes to watchdog-on and overflow flag.
// - Watchdog-on 1 enables counting and overflow detection; 0 disables the watchdog.
// - Counter overflow raises an internal reset and sets the overflow flag.
// - Counter is 8-bit up-counter on selected clock, default system clock over 8192.
// - Clock-select 0 picks system clock over 8192; 1 picks subclock over 32.
`ifndef FPEC_DEFINES_SVH
`define FPEC_DEFINES_SVH
// Register indices; each register is one 32-bit word at four times its index on the bus.
`define FPEC_IDX_FLASH_CTRL   16'hf020
`define FPEC_IDX_WD_CTRL      16'hffc0
`define FPEC_IDX_WD_COUNT     16'hffc1
`define FPEC_IDX_PORT_MODE2   16'hffe0
`define FPEC_IDX_IRQ_STATUS   16'hff00
`define FPEC_IDX_IRQ_MASK     16'hff04
`define FPEC_OFS_FLASH_CTRL   {`FPEC_IDX_FLASH_CTRL, 2'b00}
`define FPEC_OFS_WD_CTRL      {`FPEC_IDX_WD_CTRL, 2'b00}
`define FPEC_OFS_WD_COUNT     {`FPEC_IDX_WD_COUNT, 2'b00}
`define FPEC_OFS_PORT_MODE2   {`FPEC_IDX_PORT_MODE2, 2'b00}
`define FPEC_OFS_IRQ_STATUS   {`FPEC_IDX_IRQ_STATUS, 2'b00}
`define FPEC_OFS_IRQ_MASK     {`FPEC_IDX_IRQ_MASK, 2'b00}
`define FPEC_FC_WREN          6
`define FPEC_FC_ESETUP        5
`define FPEC_FC_PSETUP        4
`define FPEC_FC_EVFY          3
`define FPEC_FC_PVFY          2
`define FPEC_FC_E             1
`define FPEC_FC_P             0
`define FPEC_WD_CNT_WE        6
`define FPEC_WD_CTL_WE        4
`define FPEC_WD_ON            2
`define FPEC_WD_FLAG          0
`define FPEC_PM2_CKS          2
`define FPEC_FC_RESET         8'h00
`define FPEC_WD_CTRL_RESET    8'haa
`define FPEC_WD_COUNT_RESET   8'h00
`define FPEC_PM2_RESET        8'h00
`define FPEC_SYS_DIV          8192
`define FPEC_SUB_DIV          32
`define FPEC_RST_PULSE_CYC    8'h08
`endif

// ==== logic/fpec_pkg.sv ====
// Types shared by the flash control block.
package fpec_pkg;
  typedef enum logic [1:0] {
    FPEC_IDLE   = 2'b00,
    FPEC_SETUP  = 2'b01,
    FPEC_PROG   = 2'b10,
    FPEC_VERIFY = 2'b11
  } fpec_mode_t;
endpackage : fpec_pkg

// ==== testbench/fpec_top_tb.sv ====
// Self-checking bench for the flash control registers and the protected watchdog.
`timescale 1ns/1ps
`include "fpec_defines.svh"
module fpec_top_tb;
  import fpec_pkg::*;
  // Short prescalers keep the watchdog overflow runs brief.
  localparam int SDIV = 16;
  localparam int UDIV = 4;
  // Shortest program pulse, 10 us at 25 ns per cycle.
  localparam int PULSE_CYC = 400;
  localparam logic [17:0] A_FL = `FPEC_OFS_FLASH_CTRL;
  localparam logic [17:0] A_WD = `FPEC_OFS_WD_CTRL;
  localparam logic [17:0] A_CN = `FPEC_OFS_WD_COUNT;
  localparam logic [17:0] A_PM = `FPEC_OFS_PORT_MODE2;
  localparam logic [17:0] A_IS = `FPEC_OFS_IRQ_STATUS;
  localparam logic [17:0] A_IM = `FPEC_OFS_IRQ_MASK;
  logic        i_clk = 1'b0;
  logic        i_rst_n = 1'b0;
  logic        i_sub_tick = 1'b0;
  logic        i_psel = 1'b0;
  logic        i_penable = 1'b0;
  logic        i_pwrite = 1'b0;
  logic [17:0] i_paddr = 18'h00000;
  logic [31:0] i_pwdata = 32'h00000000;
  logic [31:0] o_prdata;
  logic        o_pready, o_pslverr, o_program_mode, o_erase_mode;
  logic        o_program_setup, o_erase_verify, o_program_verify, o_wd_reset, o_irq;
  fpec_mode_t  o_mode;
  logic        sub_on = 1'b0;
  logic [7:0]  d, wd_exp, c;
  logic [31:0] q;
  logic        e;
  int          num_errors = 0;
  int          checks_done = 0;
  int          seed, i, n;
  fpec_top #(.SYS_DIV(SDIV), .SUB_DIV(UDIV)) dut (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_sub_tick(i_sub_tick), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
    .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .o_program_mode(o_program_mode), .o_erase_mode(o_erase_mode),
    .o_program_setup(o_program_setup), .o_erase_verify(o_erase_verify),
    .o_program_verify(o_program_verify), .o_mode(o_mode), .o_wd_reset(o_wd_reset),
    .o_irq(o_irq));
  initial begin
    forever #12.5 i_clk = ~i_clk;
  end
  // Subclock ticks every other cycle only while a scenario asks for them.
  always @(posedge i_clk) i_sub_tick <= sub_on & ~i_sub_tick;
  function automatic logic [31:0] fl_out(input logic [7:0] v);
    fl_out = {27'h0, v[6] & v[4] & v[0], v[6] & v[5] & v[1], v[6] & v[4], v[3], v[2]};
  endfunction : fl_out
  function automatic logic [1:0] fl_mode(input logic [7:0] v);
    if (v[6] & ((v[4] & v[0]) | (v[5] & v[1]))) fl_mode = FPEC_PROG;
    else if (v[3] | v[2]) fl_mode = FPEC_VERIFY;
    else if (v[5] | v[4]) fl_mode = FPEC_SETUP;
    else fl_mode = FPEC_IDLE;
  endfunction : fl_mode
  function automatic logic [7:0] wd_next(input logic [7:0] cur, input logic [7:0] w);
    wd_next = cur;
    if (!w[7]) wd_next[6] = w[6];
    if (!w[5]) wd_next[4] = w[4];
    if (!w[3] && cur[4]) wd_next[2] = w[2];
    if (!w[1] && cur[4]) wd_next[0] = w[0];
  endfunction : wd_next
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic stop_test();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : stop_test
  task automatic apb(input logic wr, input logic [17:0] a, input logic [7:0] v,
                     output logic [31:0] rq, output logic er);
    int k;
    @(posedge i_clk);
    i_psel <= 1'b1;
    i_pwrite <= wr;
    i_paddr <= a;
    i_pwdata <= {24'h0, v};
    @(posedge i_clk);
    i_penable <= 1'b1;
    k = 0;
    do begin
      @(posedge i_clk);
      k++;
    end while (o_pready !== 1'b1);
    check("pready_latency", 32'(k), 32'h1);
    rq = o_prdata;
    er = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [17:0] a, input logic [7:0] v);
    apb(1'b1, a, v, q, e);
  endtask : wr
  task automatic rchk(input string what, input logic [17:0] a, input logic [31:0] exp,
                      input logic [31:0] msk);
    apb(1'b0, a, 8'h00, q, e);
    check(what, q & msk, exp);
  endtask : rchk
  task automatic wdw(input logic [7:0] v);
    wr(A_WD, v);
    wd_exp = wd_next(wd_exp, v);
  endtask : wdw
  task automatic do_reset();
    i_rst_n <= 1'b0;
    repeat (12) @(posedge i_clk);
    check("outputs_in_reset", 32'({o_pready, o_program_mode, o_wd_reset, o_irq}), 32'h0);
    i_rst_n <= 1'b1;
  endtask : do_reset
  task automatic wait_wd(input int lim);
    n = 0;
    while (o_wd_reset !== 1'b1 && n < lim) begin
      @(posedge i_clk);
      n++;
    end
  endtask : wait_wd
  initial begin
    repeat (20000) @(posedge i_clk);
    num_errors++;
    stop_test();
  end
  initial begin
    seed = 91;
    do_reset();
    for (i = 0; i < 24; i++) begin
      d = (i == 0) ? 8'h51 : (i == 1) ? 8'h11 : (i == 2) ? 8'h41 :
          (i == 3) ? 8'h62 : 8'($random(seed));
      wr(A_FL, d);
      repeat (2) @(posedge i_clk);
      check("flash_modes", 32'({o_program_mode, o_erase_mode, o_program_setup,
            o_erase_verify, o_program_verify}), fl_out(d));
      check("flash_state", 32'(o_mode), {30'h0, fl_mode(d)});
      rchk("flash_control_1", A_FL, {25'h0, d[6:0]}, 32'hffffffff);
    end
    // Ordered pulse: setup first, pulse held, pulse cleared before setup, then verify.
    wr(A_FL, 8'h50);
    wr(A_FL, 8'h51);
    repeat (PULSE_CYC) @(posedge i_clk);
    check("pulse_held", 32'({o_program_mode, o_mode}), {29'h0, 1'b1, FPEC_PROG});
    wr(A_FL, 8'h50);
    repeat (2) @(posedge i_clk);
    check("pulse_cleared", 32'({o_program_mode, o_program_setup}), 32'h1);
    wr(A_FL, 8'h44);
    repeat (2) @(posedge i_clk);
    check("unit_verify", 32'({o_program_verify, o_mode}), {29'h0, 1'b1, FPEC_VERIFY});
    do_reset();
    rchk("flash_control_1", A_FL, 32'h0, 32'hffffffff);
    rchk("watchdog_control_status", A_WD, 32'haa, 32'hffffffff);
    rchk("watchdog_counter", A_CN, 32'h0, 32'hffffffff);
    rchk("port_mode_two", A_PM, 32'h0, 32'hffffffff);
    rchk("irq_status", A_IS, 32'h0, 32'hffffffff);
    apb(1'b0, 18'h01234, 8'h00, q, e);
    check("unmapped_read", {q[31:1], e}, 32'h1);
    wd_exp = 8'haa;
    for (i = 0; i < 12; i++) begin
      wdw(8'($random(seed)));
      rchk("watchdog_control_status", A_WD, {24'h0, wd_exp & 8'h55}, 32'h55);
    end
    wdw(8'h10);
    wdw(8'h10);
    apb(1'b0, A_CN, 8'h00, q, e);
    c = q[7:0];
    wr(A_CN, 8'h5a);
    rchk("counter_locked", A_CN, {24'h0, c}, 32'hffffffff);
    wdw(8'h50);
    wr(A_CN, 8'hfb);
    rchk("counter_written", A_CN, 32'hfb, 32'hffffffff);
    repeat (3 * SDIV) @(posedge i_clk);
    rchk("counter_idle", A_CN, 32'hfb, 32'hffffffff);
    wdw(8'h54);
    wait_wd(400);
    check("overflow_time", 32'(n >= 4 * SDIV && n <= 5 * SDIV + 4), 32'h1);
    n = 0;
    while (o_wd_reset === 1'b1 && n < 20) begin
      @(posedge i_clk);
      n++;
    end
    check("reset_pulse_len", 32'(n), 32'h8);
    wd_exp[0] = 1'b1;
    rchk("overflow_flag", A_WD, {24'h0, wd_exp & 8'h55}, 32'h55);
    wdw(8'h50);
    rchk("flag_cleared", A_WD, 32'h50, 32'h55);
    wr(A_PM, 8'h04);
    rchk("port_mode_two", A_PM, 32'h04, 32'hffffffff);
    wr(A_CN, 8'hfe);
    wdw(8'h54);
    repeat (4 * SDIV) @(posedge i_clk);
    check("no_sysclk_count", 32'(o_wd_reset), 32'h0);
    rchk("counter_held", A_CN, 32'hfe, 32'hffffffff);
    sub_on <= 1'b1;
    wait_wd(200);
    check("sub_overflow", 32'(n >= 2 * UDIV && n <= 4 * UDIV + 8), 32'h1);
    sub_on <= 1'b0;
    wdw(8'h50);
    wr(A_FL, 8'h51);
    wr(A_FL, 8'h00);
    rchk("irq_status", A_IS, 32'h03, 32'hffffffff);
    check("irq_masked", 32'(o_irq), 32'h0);
    for (i = 0; i < 2; i++) begin
      wr(A_IM, 8'h01 << i);
      rchk("irq_mask", A_IM, {24'h0, 8'h01 << i}, 32'hffffffff);
      repeat (2) @(posedge i_clk);
      check("irq_raised", 32'(o_irq), 32'h1);
      wr(A_IS, 8'h01 << i);
      repeat (2) @(posedge i_clk);
      check("irq_cleared", 32'(o_irq), 32'h0);
    end
    rchk("irq_status", A_IS, 32'h00, 32'hffffffff);
    stop_test();
  end
endmodule : fpec_top_tb
